// ### verilog/mcuore_exec.sv
`timescale 1ns/100ps
`default_nettype none
module mcuore_exec #(
	parameter int unsigned ADDR_W      = mcuore_pkg::MCUORE_ADDR_W,
	parameter int unsigned PC_W        = mcuore_pkg::MCUORE_PC_W,
	parameter int unsigned STACK_DEPTH = mcuore_pkg::MCUORE_STACK_DEPTH
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   instr_valid,
	input  wire mcuore_pkg::mcuore_op_e instr_op,
	input  wire logic [7:0]             instr_imm,
	input  wire logic [ADDR_W-1:0]      instr_addr,
	output logic                        instr_ready,
	input  wire logic                   irq_req,
	output logic                        irq_ack,
	input  wire logic [ADDR_W-1:0]      obs_addr,
	output logic [7:0]                  obs_data,
	output logic [7:0]                  acc,
	output logic                        null_result_flag,
	output logic                        master_irq_enable,
	output logic [PC_W-1:0]             pc
);
	import mcuore_pkg::*;

	localparam int unsigned MEM_DEPTH = 1 << ADDR_W;
	localparam int unsigned SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	if (PC_W < 11 || ADDR_W < 1 || ADDR_W > 10
		|| STACK_DEPTH != (1 << SP_W)) begin : g_bad_params
		$error("mcuore_exec: unsupported parameter values");
	end

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0]      acc_q;
	logic            z_q;
	logic            emi_q;
	logic [PC_W-1:0] pc_q;
	logic [SP_W-1:0] sp_q;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [7:0]      mem_q [MEM_DEPTH];
	logic [7:0]      obs_q;

	// ************************************************************
	// decode
	// ************************************************************
	wire logic            irq_take;
	wire logic            exec;
	wire logic            is_pop;
	wire logic [7:0]      cur_mem;
	wire logic [SP_W-1:0] sp_dec;
	wire logic [PC_W-1:0] pc_inc;
	wire logic [PC_W-1:0] pop_pc;
	wire logic [7:0]      acc_nx;
	wire logic [7:0]      mem_nx;
	wire logic            acc_we;
	wire logic            mem_we;
	wire logic            z_nx;
	wire logic            z_we;

	// interrupt is checked before any instruction, so a request pending
	// while interrupt_exit retires is served before the main program resumes
	assign irq_take    = emi_q & irq_req;
	assign instr_ready = ~irq_take;
	assign irq_ack     = irq_take;
	assign exec        = instr_valid & instr_ready;
	assign is_pop      = (instr_op == MCUORE_OP_RET)
		|| (instr_op == MCUORE_OP_RET_IMM) || (instr_op == MCUORE_OP_INTERRUPT_EXIT);
	assign cur_mem     = mem_q[instr_addr];
	assign sp_dec      = sp_q - SP_W'(1);
	assign pc_inc      = pc_q + PC_W'(1);
	assign pop_pc      = stack_q[sp_dec];

	mcuore_alu u_alu (
		.op       (instr_op),
		.acc      (acc_q),
		.mem_byte (cur_mem),
		.imm      (instr_imm),
		.acc_nx   (acc_nx),
		.acc_we   (acc_we),
		.mem_nx   (mem_nx),
		.mem_we   (mem_we),
		.z_nx     (z_nx),
		.z_we     (z_we)
	);

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pc_q <= PC_W'(MCUORE_PC_RESET);
			sp_q <= '0;
			// empty stack pops the reset address, never an unknown
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_q[i] <= PC_W'(MCUORE_PC_RESET);
			end
		end else if (irq_take) begin
			stack_q[sp_q] <= pc_q;
			sp_q <= sp_q + SP_W'(1);
			pc_q <= PC_W'(MCUORE_IRQ_VECTOR);
		end else if (exec && is_pop) begin
			sp_q <= sp_dec;
			pc_q <= pop_pc;
		end else if (exec) begin
			pc_q <= pc_inc;
		end
	end

	// the vector clears the global gate; interrupt_exit reopens it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			emi_q <= MCUORE_EMI_RESET;
		end else if (irq_take) begin
			emi_q <= 1'b0;
		end else if (exec && instr_op == MCUORE_OP_INTERRUPT_EXIT) begin
			emi_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_q <= MCUORE_ACC_RESET;
			z_q   <= MCUORE_Z_RESET;
		end else if (exec) begin
			if (acc_we) begin
				acc_q <= acc_nx;
			end
			if (z_we) begin
				z_q <= z_nx;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					mem_q[gi] <= MCUORE_MEM_RESET;
				end else if (exec && mem_we && instr_addr == ADDR_W'(gi)) begin
					mem_q[gi] <= mem_nx;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			obs_q <= MCUORE_MEM_RESET;
		end else begin
			obs_q <= mem_q[obs_addr];
		end
	end

	assign acc               = acc_q;
	assign null_result_flag  = z_q;
	assign master_irq_enable = emi_q;
	assign pc                = pc_q;
	assign obs_data          = obs_q;

	// ************************************************************
	// checks
	// ************************************************************
	wire logic run_idle;
	wire logic run_ormem;
	wire logic run_orimm;
	wire logic run_tomem;
	wire logic run_ret;
	wire logic run_retimm;
	wire logic run_interrupt_exit;
	wire logic run_rot;
	assign run_idle   = exec && instr_op == MCUORE_OP_IDLE;
	assign run_ormem  = exec && instr_op == MCUORE_OP_OR_MEM;
	assign run_orimm  = exec && instr_op == MCUORE_OP_OR_IMM;
	assign run_tomem  = exec && instr_op == MCUORE_OP_OR_TO_MEM;
	assign run_ret    = exec && instr_op == MCUORE_OP_RET;
	assign run_retimm = exec && instr_op == MCUORE_OP_RET_IMM;
	assign run_interrupt_exit   = exec && instr_op == MCUORE_OP_INTERRUPT_EXIT;
	assign run_rot    = exec && instr_op == MCUORE_OP_ROT_LEFT;

	sequence interrupt_exit_with_req;
		run_interrupt_exit && irq_req ##1 irq_req;
	endsequence

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	idle_keeps_a: assert property (run_idle |=> $stable(acc_q) && $stable(z_q)
		&& pc_q == $past(pc_inc) && $stable(emi_q))
		else $error("idle instruction changed state");
	or_mem_a: assert property (run_ormem |=> acc_q == $past(acc_q | cur_mem))
		else $error("or with memory gave wrong acc");
	or_imm_a: assert property (run_orimm |=> acc_q == $past(acc_q | instr_imm))
		else $error("or with immediate gave wrong acc");
	or_to_mem_a: assert property (run_tomem |=> $stable(acc_q)
		&& mem_q[$past(instr_addr)] == $past(acc_q | cur_mem))
		else $error("or into memory wrong");
	ret_pop_a: assert property (run_ret |=> pc_q == $past(pop_pc)
		&& $stable(z_q) && $stable(acc_q))
		else $error("return did not restore pc");
	ret_imm_a: assert property (run_retimm |=> pc_q == $past(pop_pc)
		&& acc_q == $past(instr_imm) && $stable(z_q))
		else $error("return with immediate wrong");
	interrupt_exit_sets_a: assert property (run_interrupt_exit |=> emi_q && $stable(z_q)
		&& pc_q == $past(pop_pc))
		else $error("interrupt exit did not reopen gate");
	gate_closed_a: assert property (!emi_q |-> !irq_ack && instr_ready)
		else $error("interrupt taken while gate closed");
	gate_holds_sp_a: assert property (!emi_q && irq_req && !(exec && is_pop)
		|=> sp_q == $past(sp_q) && !emi_q)
		else $error("stack pushed while gate closed");
	irq_entry_a: assert property (irq_ack |=> pc_q == PC_W'(MCUORE_IRQ_VECTOR)
		&& !emi_q && stack_q[$past(sp_q)] == $past(pc_q))
		else $error("interrupt entry did not push and vector");
	pend_first_a: assert property (interrupt_exit_with_req |-> irq_ack && !instr_ready
		##1 pc_q == PC_W'(MCUORE_IRQ_VECTOR))
		else $error("pending interrupt not served first");
	rot_left_a: assert property (run_rot |=> $stable(acc_q) && $stable(z_q)
		&& mem_q[$past(instr_addr)] == {$past(cur_mem[6:0]), $past(cur_mem[7])})
		else $error("rotate left wrong");
	zero_flag_a: assert property ((run_ormem || run_orimm || run_tomem)
		|=> z_q == ($past(acc_q | (run_orimm ? instr_imm : cur_mem)) == 8'h00))
		else $error("zero flag wrong");
endmodule
`default_nettype wire

// ### verilog/mcuore_pkg.sv
// Contract
// - idle_instruction changes nothing, pc advances
// - or memory into acc, update zero flag
// - or immediate into acc, update zero flag
// - or acc into memory byte, acc kept
// - subroutine_exit pops pc, flags untouched
// - pop pc and load acc with immediate
// - interrupt_exit pops pc, sets master_irq_enable
// - master_irq_enable gates every interrupt
// - pending interrupt served before resuming main
// - rotate memory byte left, bit7 to bit0
package mcuore_pkg;
	localparam int unsigned MCUORE_DATA_W      = 8;
	localparam int unsigned MCUORE_PC_W        = 11;
	localparam int unsigned MCUORE_ADDR_W      = 6;
	localparam int unsigned MCUORE_STACK_DEPTH = 4;
	localparam logic [10:0] MCUORE_PC_RESET    = 11'h000;
	localparam logic [10:0] MCUORE_IRQ_VECTOR  = 11'h004;
	localparam logic [7:0]  MCUORE_ACC_RESET   = 8'h00;
	localparam logic [7:0]  MCUORE_MEM_RESET   = 8'h00;
	localparam logic        MCUORE_Z_RESET     = 1'b0;
	localparam logic        MCUORE_EMI_RESET   = 1'b0;

	typedef enum logic [2:0] {
		MCUORE_OP_IDLE,
		MCUORE_OP_OR_MEM,
		MCUORE_OP_OR_IMM,
		MCUORE_OP_OR_TO_MEM,
		MCUORE_OP_RET,
		MCUORE_OP_RET_IMM,
		MCUORE_OP_INTERRUPT_EXIT,
		MCUORE_OP_ROT_LEFT
	} mcuore_op_e;
endpackage

// ### verilog/mcuore_alu.sv
`timescale 1ns/100ps
`default_nettype none
module mcuore_alu (
	input  wire mcuore_pkg::mcuore_op_e op,
	input  wire logic [7:0]             acc,
	input  wire logic [7:0]             mem_byte,
	input  wire logic [7:0]             imm,
	output logic [7:0]                  acc_nx,
	output logic                        acc_we,
	output logic [7:0]                  mem_nx,
	output logic                        mem_we,
	output logic                        z_nx,
	output logic                        z_we
);
	import mcuore_pkg::*;

	wire logic [7:0] or_src;
	wire logic [7:0] or_res;
	wire logic [7:0] rot_res;
	wire logic       is_or;

	assign or_src  = (op == MCUORE_OP_OR_IMM) ? imm : mem_byte;
	assign or_res  = acc | or_src;
	assign rot_res = {mem_byte[6:0], mem_byte[7]};
	assign is_or   = (op == MCUORE_OP_OR_MEM) || (op == MCUORE_OP_OR_IMM)
		|| (op == MCUORE_OP_OR_TO_MEM);

	assign acc_we = (op == MCUORE_OP_OR_MEM) || (op == MCUORE_OP_OR_IMM)
		|| (op == MCUORE_OP_RET_IMM);
	assign acc_nx = (op == MCUORE_OP_RET_IMM) ? imm : or_res;
	assign mem_we = (op == MCUORE_OP_OR_TO_MEM) || (op == MCUORE_OP_ROT_LEFT);
	assign mem_nx = (op == MCUORE_OP_ROT_LEFT) ? rot_res : or_res;
	assign z_we   = is_or;
	assign z_nx   = (or_res == 8'h00);
endmodule
`default_nettype wire

// ### tb/mcu_or_return_rotate_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_or_return_rotate_exec_tb;
	import mcuore_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        instr_valid = 1'b0;
	mcuore_op_e  instr_op = MCUORE_OP_IDLE;
	logic [7:0]  instr_imm = 8'h00;
	logic [5:0]  instr_addr = 6'h00;
	logic [5:0]  obs_addr = 6'h00;
	logic        irq_req = 1'b0;
	logic        instr_ready;
	logic        irq_ack;
	logic [7:0]  obs_data;
	logic [7:0]  acc;
	logic        null_result_flag;
	logic        master_irq_enable;
	logic [10:0] pc;
	// ****************
	// reference state
	// ****************
	logic [7:0]  m_acc;
	logic [7:0]  m_obs;
	logic [7:0]  m_mem [64];
	logic [10:0] m_pc;
	logic [10:0] m_stk [4];
	logic [1:0]  m_sp;
	logic        m_z;
	logic        m_emi;
	int          n_errors = 0;
	int          checked = 0;

	always #10 clk = ~clk;

	mcuore_exec mcuore_exec_i (.clk(clk), .reset(reset),
		.instr_valid(instr_valid), .instr_op(instr_op),
		.instr_imm(instr_imm), .instr_addr(instr_addr),
		.instr_ready(instr_ready), .irq_req(irq_req), .irq_ack(irq_ack),
		.obs_addr(obs_addr), .obs_data(obs_data), .acc(acc),
		.null_result_flag(null_result_flag),
		.master_irq_enable(master_irq_enable), .pc(pc));

	task automatic chk(input logic [10:0] seen, input logic [10:0] exp,
		input string what);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic look;
		chk(acc, m_acc, "acc");
		chk(null_result_flag, m_z, "zero");
		chk(master_irq_enable, m_emi, "emi");
		chk(pc, m_pc, "pc");
		// obs byte is read before the same edge's write lands
		chk(obs_data, m_obs, "mem");
	endtask

	// ****************
	// one instruction
	// ****************
	task automatic step(input logic v, input mcuore_op_e op,
		input logic [7:0] imm, input logic [5:0] a, input logic irq);
		logic [7:0] r;
		logic [5:0] oa;
		logic       tk;
		oa = 6'($urandom % 8);
		tk = m_emi & irq;
		instr_valid <= v & ~tk;
		instr_op <= op;
		instr_imm <= imm;
		instr_addr <= a;
		irq_req <= irq;
		obs_addr <= oa;
		@(negedge clk);
		look();
		chk(instr_ready, !tk, "ready");
		chk(irq_ack, tk, "ack");
		@(posedge clk);
		m_obs = m_mem[oa];
		if (tk) begin
			m_stk[m_sp] = m_pc;
			m_sp++;
			m_pc = MCUORE_IRQ_VECTOR;
			m_emi = 1'b0;
		end else if (v) begin
			m_pc++;
			r = m_acc | ((op == MCUORE_OP_OR_IMM) ? imm : m_mem[a]);
			case (op)
				MCUORE_OP_OR_MEM, MCUORE_OP_OR_IMM, MCUORE_OP_OR_TO_MEM: begin
					if (op == MCUORE_OP_OR_TO_MEM) m_mem[a] = r;
					else m_acc = r;
					m_z = (r == 8'h00);
				end
				MCUORE_OP_ROT_LEFT: begin
					m_mem[a] = {m_mem[a][6:0], m_mem[a][7]};
				end
				MCUORE_OP_RET, MCUORE_OP_RET_IMM, MCUORE_OP_INTERRUPT_EXIT: begin
					m_sp--;
					m_pc = m_stk[m_sp];
					if (op == MCUORE_OP_RET_IMM) m_acc = imm;
					if (op == MCUORE_OP_INTERRUPT_EXIT) m_emi = 1'b1;
				end
				default: ;
			endcase
		end
	endtask

	initial begin
		void'($urandom(32'h966164c6));
		m_acc = MCUORE_ACC_RESET;
		m_obs = 8'h00;
		foreach (m_mem[i]) m_mem[i] = MCUORE_MEM_RESET;
		m_pc = MCUORE_PC_RESET;
		foreach (m_stk[i]) m_stk[i] = MCUORE_PC_RESET;
		m_sp = 2'h0;
		m_z = MCUORE_Z_RESET;
		m_emi = MCUORE_EMI_RESET;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		// request held off by the global gate while it is clear
		step(1'b1, MCUORE_OP_IDLE, 8'h00, 6'h00, 1'b1);
		step(1'b1, MCUORE_OP_OR_IMM, 8'h00, 6'h00, 1'b0);
		step(1'b1, MCUORE_OP_OR_IMM, 8'h81, 6'h00, 1'b0);
		step(1'b1, MCUORE_OP_OR_TO_MEM, 8'h00, 6'h05, 1'b0);
		step(1'b1, MCUORE_OP_ROT_LEFT, 8'h00, 6'h05, 1'b0);
		step(1'b1, MCUORE_OP_OR_MEM, 8'h00, 6'h3F, 1'b0);
		step(1'b1, MCUORE_OP_INTERRUPT_EXIT, 8'h00, 6'h00, 1'b0);
		step(1'b1, MCUORE_OP_IDLE, 8'h00, 6'h00, 1'b1);
		step(1'b1, MCUORE_OP_RET_IMM, 8'h00, 6'h00, 1'b0);
		step(1'b1, MCUORE_OP_OR_TO_MEM, 8'h00, 6'h06, 1'b0);
		step(1'b1, MCUORE_OP_INTERRUPT_EXIT, 8'h00, 6'h00, 1'b1);
		step(1'b1, MCUORE_OP_RET, 8'h00, 6'h00, 1'b1);
		repeat (3000) begin
			step(($urandom % 4) != 0, mcuore_op_e'($urandom % 8),
				($urandom % 4 == 0) ? 8'h00 : 8'($urandom),
				6'($urandom % (($urandom % 2) ? 8 : 64)),
				($urandom % 4) == 0);
		end
		@(negedge clk);
		look();
		test_done();
	end
endmodule
`default_nettype wire
